// *** xau_exc_unit.sv ***
`timescale 1ns/10ps
`default_nettype none
module xau_exc_unit
  import xau_pkg::*;
(
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // apb slave
  input  wire logic         psel_i,
  input  wire logic         penable_i,
  input  wire logic         pwrite_i,
  input  wire logic [7:0]   paddr_i,
  input  wire logic [31:0]  pwdata_i,
  output logic [31:0]       prdata_o,
  output logic              pready_o,
  output logic              pslverr_o,
  // core decode and status
  input  wire xau_dec_t     dec_i,
  input  wire logic [31:0]  proc_status_word_i,
  output logic              exc_busy_o,
  // fpu
  input  wire xau_fpu_rpt_t fpu_rpt_i,
  output logic              fpu_suspend_o,
  output logic              fpu_exc_o,
  // interrupt controller and bus
  input  wire logic         irq_req_i,
  input  wire logic [7:0]   irq_vec_i,
  input  wire logic         flash_loader_download_i,
  input  wire logic         bus_err_i,
  output logic              irq_ack_o,
  // stacking and vectoring
  output xau_stk_t          stk_o,
  output xau_vec_t          vec_o
);

  // registers
  logic [31:0] fpscw_r;
  logic [31:0] vector_base_r;
  logic [31:0] stack_pointer_r;
  xau_state_t  state_r;
  xau_exc_t    kind_r;
  logic [31:0] ret_r;
  logic [31:0] voff_r;
  logic        nested_r;
  xau_cls_t    prev_cls_r;
  logic [31:0] slot_target_r;
  logic [31:0] fpu_ret_r;
  logic        pend_be_r;
  logic        pend_irq_r;
  logic        pend_fpu_r;
  logic        pend_adr_r;
  logic [7:0]  irq_vec_r;

  // combinational
  logic        take;
  xau_exc_t    take_kind;
  logic [31:0] take_ret;
  logic [31:0] take_voff;
  logic [2:0]  allow;
  logic        fp_hit;
  logic        apb_wr;
  logic        apb_rd;
  logic [31:0] sp_dec;
  logic        sp_bad;
  logic        adr_raise;
  logic        chain_adr;
  logic [31:0] vec_addr;

  // decoded strobes and views
  logic        wr_fpscw;
  logic        wr_vbase;
  logic        wr_sptr;
  logic        pushing;
  logic        stk_fault;
  logic        vb_fault;
  logic        take_be;
  logic        take_irq;
  logic        take_fpu;
  logic [4:0]  fp_en;
  logic [31:0] status_view;

  // {bus error, interrupt, fp exception} accepted after the given class
  function automatic logic [2:0] accept_mask(input xau_cls_t c);
    logic [2:0] m;
    m = 3'h7;
    unique case (c)
      XAU_CLS_DBRANCH: m = 3'h0;
      XAU_CLS_SYSREG:  m = 3'h1;
      XAU_CLS_FP:      m = 3'h1;
      XAU_CLS_PLAIN, XAU_CLS_PCWRITE, XAU_CLS_TRAP, XAU_CLS_UNDEF: m = 3'h7;
    endcase
    return m;
  endfunction

  function automatic logic fp_can_trap(input xau_fpop_t op);
    logic r;
    r = 1'b0;
    unique case (op)
      XAU_FP_ADD, XAU_FP_SUB, XAU_FP_MUL, XAU_FP_DIV, XAU_FP_MAC, XAU_FP_CMPEQ,
      XAU_FP_CMPGT, XAU_FP_NEG, XAU_FP_ABS, XAU_FP_TRC: r = 1'b1;
      XAU_FP_FLOAT, XAU_FP_MOVE: r = 1'b0;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] word_index(input logic [7:0] v);
    return {22'h0, v, 2'h0};
  endfunction

  // register select, one call per writable register
  function automatic logic reg_hit(input logic wr, input logic [7:0] a, input logic [7:0] off);
    return wr && (a == off);
  endfunction

  assign apb_wr = psel_i & penable_i & pready_o & pwrite_i;
  assign apb_rd = psel_i & penable_i & ~pready_o;

  // write strobes land only in the cycle that pready is seen
  assign wr_fpscw = reg_hit(apb_wr, paddr_i, XAU_ADDR_FPSCW);
  assign wr_vbase = reg_hit(apb_wr, paddr_i, XAU_ADDR_VBASE);
  assign wr_sptr  = reg_hit(apb_wr, paddr_i, XAU_ADDR_SPTR);
  assign fp_en    = fpscw_r[XAU_EN_LSB +: 5];

  // which pending source the current entry consumes
  assign take_be  = take && (take_kind == XAU_EX_BUSERR);
  assign take_irq = take && (take_kind == XAU_EX_IRQ);
  assign take_fpu = take && (take_kind == XAU_EX_FPU);

  // status view: kind, state, nested, then pending adr, fpu, irq, bus
  assign status_view = {22'h000000, kind_r, state_r, nested_r, pend_adr_r, pend_fpu_r, pend_irq_r, pend_be_r};

  // only invalid and divide-by-zero can trap; the others are recorded only
  assign fp_hit = fpu_rpt_i.done & fp_can_trap(fpu_rpt_i.op) &
                  (|(fpu_rpt_i.cond & fp_en & XAU_TRAP_MASK));

  assign allow = accept_mask(prev_cls_r);

  // decode point arbitration, one source per entry
  always_comb begin
    take      = 1'b0;
    take_kind = XAU_EX_TRAP;
    take_ret  = dec_i.next_pc;
    take_voff = XAU_VOFF_GENILL;
    if (state_r == XAU_ST_IDLE && dec_i.valid) begin
      if (prev_cls_r == XAU_CLS_DBRANCH &&
          (dec_i.cls == XAU_CLS_UNDEF || dec_i.cls == XAU_CLS_DBRANCH ||
           dec_i.cls == XAU_CLS_PCWRITE || dec_i.cls == XAU_CLS_TRAP)) begin
        take      = 1'b1;
        take_kind = XAU_EX_SLOTIL;
        take_ret  = slot_target_r;
        take_voff = XAU_VOFF_SLOTIL;
      end else if (pend_be_r && allow[2]) begin
        take      = 1'b1;
        take_kind = XAU_EX_BUSERR;
        take_ret  = dec_i.pc;
        take_voff = XAU_VOFF_BUSERR;
      end else if (pend_fpu_r && allow[0]) begin
        take      = 1'b1;
        take_kind = XAU_EX_FPU;
        take_ret  = fpu_ret_r;
        take_voff = XAU_VOFF_FPU;
      end else if (pend_irq_r && allow[1] && !flash_loader_download_i) begin
        take      = 1'b1;
        take_kind = XAU_EX_IRQ;
        take_ret  = dec_i.pc;
        take_voff = word_index(irq_vec_r);
      end else if (dec_i.cls == XAU_CLS_TRAP) begin
        take      = 1'b1;
        take_kind = XAU_EX_TRAP;
        take_ret  = dec_i.next_pc;
        take_voff = word_index(dec_i.trap_vec);
      end else if (dec_i.cls == XAU_CLS_UNDEF) begin
        take      = 1'b1;
        take_kind = XAU_EX_GENILL;
        take_ret  = dec_i.pc;
        take_voff = XAU_VOFF_GENILL;
      end
    end
  end

  // stacking address arithmetic
  assign sp_dec    = stack_pointer_r - XAU_SP_STEP;
  assign sp_bad    = (stack_pointer_r[1:0] != 2'h0);
  assign vec_addr  = vector_base_r + voff_r;

  assign pushing   = (state_r == XAU_ST_PUSH_SR) || (state_r == XAU_ST_PUSH_PC);
  assign stk_fault = pushing && sp_bad;
  assign vb_fault  = (state_r == XAU_ST_VECTOR) && (vector_base_r[1:0] != 2'h0);
  // nested address error entries ignore their own stacking faults
  assign adr_raise = !nested_r && (stk_fault || vb_fault);
  assign chain_adr = (state_r == XAU_ST_VECTOR) && (pend_adr_r || adr_raise) && !nested_r;

  // entry sequencer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r  <= XAU_ST_IDLE;
      kind_r   <= XAU_EX_TRAP;
      ret_r    <= 32'h0000_0000;
      voff_r   <= 32'h0000_0000;
      nested_r <= 1'b0;
    end else begin
      unique case (state_r)
        XAU_ST_IDLE: begin
          if (take) begin
            state_r <= XAU_ST_PUSH_SR;
            kind_r  <= take_kind;
            ret_r   <= take_ret;
            voff_r  <= take_voff;
          end
        end
        XAU_ST_PUSH_SR: state_r <= XAU_ST_PUSH_PC;
        XAU_ST_PUSH_PC: state_r <= XAU_ST_VECTOR;
        XAU_ST_VECTOR: begin
          if (chain_adr) begin
            state_r  <= XAU_ST_PUSH_SR;
            kind_r   <= XAU_EX_ADRERR;
            voff_r   <= XAU_VOFF_ADRERR;
            nested_r <= 1'b1;
          end else begin
            state_r  <= XAU_ST_IDLE;
            nested_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // stack pointer: stacking decrements, software writes land whenever not pushing
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stack_pointer_r <= XAU_SPTR_RST;
    end else if (pushing) begin
      stack_pointer_r <= sp_dec;
    end else if (wr_sptr) begin
      stack_pointer_r <= pwdata_i;
    end
  end

  // stack write port; data is not meaningful when the pointer is misaligned
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stk_o <= '0;
    end else begin
      stk_o.we       <= pushing;
      stk_o.misalign <= stk_fault;
      stk_o.addr     <= sp_dec;
      if (sp_bad) begin
        stk_o.data <= 32'h0000_0000;
      end else if (state_r == XAU_ST_PUSH_SR) begin
        stk_o.data <= proc_status_word_i;
      end else begin
        stk_o.data <= ret_r;
      end
    end
  end

  // vector fetch request at the end of each entry
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vec_o      <= '0;
      exc_busy_o <= 1'b0;
    end else begin
      vec_o.valid <= (state_r == XAU_ST_VECTOR);
      vec_o.kind  <= kind_r;
      vec_o.addr  <= vec_addr;
      exc_busy_o  <= take || (state_r != XAU_ST_IDLE && !(state_r == XAU_ST_VECTOR && !chain_adr));
    end
  end

  // previous decoded class and delay slot target
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_cls_r    <= XAU_CLS_PLAIN;
      slot_target_r <= 32'h0000_0000;
    end else if (state_r == XAU_ST_IDLE && dec_i.valid) begin
      prev_cls_r <= take ? XAU_CLS_PLAIN : dec_i.cls;
      if (dec_i.cls == XAU_CLS_DBRANCH) begin
        slot_target_r <= dec_i.target;
      end
    end
  end

  // pending sources; a new bus error, interrupt or fp event beats the clear of the same cycle, the address error clear beats a new raise
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_be_r  <= 1'b0;
      pend_irq_r <= 1'b0;
      pend_fpu_r <= 1'b0;
      pend_adr_r <= 1'b0;
      irq_vec_r  <= 8'h00;
      fpu_ret_r  <= 32'h0000_0000;
    end else begin
      pend_be_r  <= (pend_be_r & ~take_be) | bus_err_i;
      pend_irq_r <= (pend_irq_r & ~take_irq) | irq_req_i;
      pend_fpu_r <= (pend_fpu_r & ~take_fpu) | fp_hit;
      pend_adr_r <= (pend_adr_r | adr_raise) & ~chain_adr;
      if (irq_req_i) begin
        irq_vec_r <= irq_vec_i;
      end
      if (fp_hit) begin
        fpu_ret_r <= fpu_rpt_i.next_pc;
      end
    end
  end

  // fpu handshake: suspend holds until the entry is taken
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fpu_suspend_o <= 1'b0;
      fpu_exc_o     <= 1'b0;
      irq_ack_o     <= 1'b0;
    end else begin
      fpu_exc_o     <= fp_hit;
      fpu_suspend_o <= fp_hit || (fpu_suspend_o && !take_fpu);
      irq_ack_o     <= take_irq;
    end
  end

  // fp status/control word: flags sticky, cause per instruction
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fpscw_r <= XAU_FPSCW_RST;
    end else begin
      if (wr_fpscw) begin
        fpscw_r <= pwdata_i;
      end
      if (fpu_rpt_i.done) begin
        if (fp_can_trap(fpu_rpt_i.op)) begin
          fpscw_r[XAU_CAUSE_LSB +: 5] <= fpu_rpt_i.cond;
          fpscw_r[XAU_FLAG_LSB +: 5]  <= fpu_rpt_i.cond |
            (wr_fpscw ? pwdata_i[XAU_FLAG_LSB +: 5]
                      : fpscw_r[XAU_FLAG_LSB +: 5]);
        end else begin
          fpscw_r[XAU_CAUSE_LSB +: 5] <= 5'h00;
        end
      end
    end
  end

  // vector base, software owned
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vector_base_r <= XAU_VBASE_RST;
    end else if (wr_vbase) begin
      vector_base_r <= pwdata_i;
    end
  end

  // apb: one wait state, read data captured in the first access cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o <= apb_rd;
      if (apb_rd) begin
        pslverr_o <= 1'b0;
        prdata_o  <= 32'h0000_0000;
        unique case (paddr_i)
          XAU_ADDR_FPSCW:  prdata_o <= fpscw_r;
          XAU_ADDR_VBASE:  prdata_o <= vector_base_r;
          XAU_ADDR_SPTR:   prdata_o <= stack_pointer_r;
          XAU_ADDR_STATUS: prdata_o <= status_view;
          default:         pslverr_o <= 1'b1;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** xau_exc_unit_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module xau_exc_unit_monitor
  import xau_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         nrst_i,
  input wire logic         psel_i,
  input wire logic         penable_i,
  input wire logic         pwrite_i,
  input wire logic [7:0]   paddr_i,
  input wire logic [31:0]  pwdata_i,
  input wire logic         pready_o,
  input wire xau_fpu_rpt_t fpu_rpt_i,
  input wire logic         flash_loader_download_i,
  input wire logic         exc_busy_o,
  input wire logic         fpu_suspend_o,
  input wire logic         fpu_exc_o,
  input wire logic         irq_ack_o,
  input wire xau_stk_t     stk_o,
  input wire xau_vec_t     vec_o
);
  logic [31:0] vb_r;
  logic [4:0]  en_r;
  wire logic   wr_done = psel_i && penable_i && pready_o && pwrite_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // shadow of software-written fields; hardware never touches them
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vb_r <= 32'h0000_0000;
      en_r <= 5'h00;
    end else if (wr_done && paddr_i == XAU_ADDR_VBASE) begin
      vb_r <= pwdata_i;
    end else if (wr_done && paddr_i == XAU_ADDR_FPSCW) begin
      en_r <= pwdata_i[XAU_EN_LSB +: 5];
    end
  end
  property p_fp_cause;
    fpu_exc_o == ($past(fpu_rpt_i.done) && (|($past(fpu_rpt_i.cond) & en_r & XAU_TRAP_MASK))
      && !($past(fpu_rpt_i.op) inside {XAU_FP_FLOAT, XAU_FP_MOVE}));
  endproperty
  a_fp_cause: assert property (p_fp_cause) else $error("fp exception flag wrong");
  property p_fp_susp;
    fpu_exc_o |-> fpu_suspend_o ##1 fpu_suspend_o;
  endproperty
  a_fp_susp: assert property (p_fp_susp) else $error("fpu not suspended");
  property p_fp_vec;
    vec_o.valid && vec_o.kind == XAU_EX_FPU |-> vec_o.addr == vb_r + XAU_VOFF_FPU;
  endproperty
  a_fp_vec: assert property (p_fp_vec) else $error("fp vector address wrong");
  property p_adr_vec;
    vec_o.valid && vec_o.kind == XAU_EX_ADRERR |-> vec_o.addr == vb_r + XAU_VOFF_ADRERR;
  endproperty
  a_adr_vec: assert property (p_adr_vec) else $error("address error vector wrong");
  property p_push_seq;
    $rose(exc_busy_o) |-> ##1 stk_o.we ##1 stk_o.we ##1 vec_o.valid;
  endproperty
  a_push_seq: assert property (p_push_seq) else $error("entry sequence wrong");
  property p_push_step;
    stk_o.we && !$past(stk_o.we) |=> stk_o.we && stk_o.addr == $past(stk_o.addr) - XAU_SP_STEP;
  endproperty
  a_push_step: assert property (p_push_step) else $error("second push not four below");
  property p_misal;
    stk_o.we |-> stk_o.misalign == (stk_o.addr[1:0] != 2'b00);
  endproperty
  a_misal: assert property (p_misal) else $error("misalign flag disagrees with push address");
  property p_one_entry;
    vec_o.valid |=> !vec_o.valid [*2];
  endproperty
  a_one_entry: assert property (p_one_entry) else $error("entries overlap");
  property p_flash;
    flash_loader_download_i && $past(flash_loader_download_i) && $past(flash_loader_download_i, 2)
      |-> !irq_ack_o;
  endproperty
  a_flash: assert property (p_flash) else $error("interrupt taken during download");
  property p_irq_ack;
    vec_o.valid && vec_o.kind == XAU_EX_IRQ |-> $past(irq_ack_o, 3);
  endproperty
  a_irq_ack: assert property (p_irq_ack) else $error("interrupt entry not acknowledged");
  property p_rdy;
    $rose(penable_i) && psel_i |=> pready_o ##1 !pready_o;
  endproperty
  a_rdy: assert property (p_rdy) else $error("apb wait state wrong");
  c_trap: cover property (vec_o.valid && vec_o.kind == XAU_EX_TRAP);
  c_fpu: cover property (vec_o.valid && vec_o.kind == XAU_EX_FPU);
  c_adr: cover property (vec_o.valid && vec_o.kind == XAU_EX_ADRERR);
  c_irq: cover property (vec_o.valid && vec_o.kind == XAU_EX_IRQ);
endmodule
bind xau_exc_unit xau_exc_unit_monitor u_mon (
  .clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .fpu_rpt_i,
  .flash_loader_download_i, .exc_busy_o, .fpu_suspend_o, .fpu_exc_o, .irq_ack_o, .stk_o, .vec_o
);
`default_nettype wire

// *** xau_exc_unit_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module xau_exc_unit_tb_top
  import xau_pkg::*;
();
  typedef struct packed {
    logic [31:0] kind;
    logic [31:0] va;
    logic [31:0] sa;
    logic [31:0] ret;
    logic        sc;
    logic        rc;
  } xau_note_t;
  localparam logic [31:0] SWORD = 32'h0000_00F0;
  logic clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, exc_busy_o;
  logic fpu_suspend_o, fpu_exc_o, irq_ack_o, irq_req_i, flash_loader_download_i, bus_err_i;
  logic [7:0] paddr_i, irq_vec_i, tv;
  logic [31:0] pwdata_i, prdata_o, proc_status_word_i, sra, srd, rtd, vb, sp, p;
  xau_dec_t dec_i;
  xau_fpu_rpt_t fpu_rpt_i;
  xau_stk_t stk_o;
  xau_vec_t vec_o;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] seed = 32'hE6F815BB;
  logic [32:0] rq[$];
  xau_note_t eq[$];
  xau_cls_t cl[3] = '{XAU_CLS_DBRANCH, XAU_CLS_SYSREG, XAU_CLS_FP};
  xau_exc_unit u_dut (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .dec_i, .proc_status_word_i, .exc_busy_o, .fpu_rpt_i, .fpu_suspend_o,
    .fpu_exc_o, .irq_req_i, .irq_vec_i, .flash_loader_download_i, .bus_err_i, .irq_ack_o, .stk_o, .vec_o);
  xau_stack_model #(.STATUS_WORD(SWORD)) u_stack (.clk_i, .nrst_i, .stk_i(stk_o),
    .proc_status_word_o(proc_status_word_i), .sr_addr_o(sra), .sr_o(srd), .ret_o(rtd));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic complete_run();
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    if (!w) rq.push_back(e);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic dec(input xau_cls_t c, input logic [31:0] pc, input logic [7:0] v);
    @(posedge clk_i);
    while (exc_busy_o !== 1'b0) @(posedge clk_i);
    dec_i <= '{1'b1, c, pc, pc + 32'h2, pc + 32'h40, v};
    @(posedge clk_i);
    dec_i.valid <= 1'b0;
    repeat (2) @(posedge clk_i);
    while (exc_busy_o !== 1'b0) @(posedge clk_i);
  endtask
  task automatic fp(input xau_fpop_t o, input logic [4:0] c, input logic [31:0] np);
    @(posedge clk_i);
    fpu_rpt_i <= '{1'b1, o, c, np};
    @(posedge clk_i);
    fpu_rpt_i.done <= 1'b0;
  endtask
  task automatic ev(input logic b, input logic [7:0] v);
    @(posedge clk_i);
    bus_err_i <= b;
    irq_req_i <= !b;
    irq_vec_i <= v;
    @(posedge clk_i);
    bus_err_i <= 1'b0;
    irq_req_i <= 1'b0;
  endtask
  task automatic note(input xau_exc_t k, input logic [31:0] va, input logic [31:0] r, input logic sc, rc);
    eq.push_back('{32'(k), va, sp - 32'h4, r, sc, rc});
    sp = sp - 32'h8;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // results are judged where they appear, against the oldest note
  always @(posedge clk_i) begin
    xau_note_t n;
    logic [32:0] r;
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
    if (pready_o === 1'b1 && pwrite_i === 1'b0) begin
      r = (rq.size() > 0) ? rq.pop_front() : 'x;
      chk(prdata_o, r[31:0]);
      chk({31'h0, pslverr_o}, {31'h0, r[32]});
    end
    if (vec_o.valid === 1'b1) begin
      n = (eq.size() > 0) ? eq.pop_front() : 'x;
      chk({29'h0, vec_o.kind}, n.kind);
      chk(vec_o.addr, n.va);
      chk(sra, n.sa);
      if (n.sc !== 1'b0) chk(srd, SWORD);
      if (n.rc !== 1'b0) chk(rtd, n.ret);
    end
  end
  initial begin
    {nrst_i, psel_i, penable_i, pwrite_i, irq_req_i, flash_loader_download_i, bus_err_i} = 7'h00;
    paddr_i = 8'h00;
    pwdata_i = 32'h0000_0000;
    irq_vec_i = 8'h00;
    dec_i = '0;
    fpu_rpt_i = '0;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    apb(0, XAU_ADDR_FPSCW, 0, {1'b0, XAU_FPSCW_RST});
    apb(0, XAU_ADDR_VBASE, 0, {1'b0, XAU_VBASE_RST});
    apb(0, XAU_ADDR_SPTR, 0, {1'b0, XAU_SPTR_RST});
    apb(0, 8'h10, 0, 33'h1_0000_0000);
    vb = 32'h0000_0400;
    sp = 32'h0000_2000;
    apb(1, XAU_ADDR_VBASE, vb, 0);
    apb(1, XAU_ADDR_SPTR, sp, 0);
    repeat (2) begin
      p = rnd() & 32'hFFFF_FFFE;
      tv = p[15:8];
      note(XAU_EX_TRAP, vb + {22'h0, tv, 2'b00}, p + 32'h2, 1, 1);
      dec(XAU_CLS_TRAP, p, tv);
    end
    apb(0, XAU_ADDR_SPTR, 0, {1'b0, sp});
    foreach (cl[i]) begin
      dec(cl[i], p, 8'h00);
      ev(1'b1, 8'h00);
      dec(XAU_CLS_PLAIN, p, 8'h00);
      note(XAU_EX_BUSERR, vb + XAU_VOFF_BUSERR, p, 1, 1);
      dec(XAU_CLS_PLAIN, p, 8'h00);
    end
    apb(1, XAU_ADDR_FPSCW, 32'h0000_0F80, 0);
    fp(XAU_FP_ADD, 5'h04, p);
    apb(0, XAU_ADDR_FPSCW, 0, {1'b0, 32'h0000_4F90});
    fp(XAU_FP_FLOAT, 5'h10, p);
    dec(XAU_CLS_PLAIN, p, 8'h00);
    flash_loader_download_i <= 1'b1;
    tv = 8'(rnd());
    ev(1'b0, tv);
    dec(XAU_CLS_SYSREG, p, 8'h00);
    fp(XAU_FP_DIV, 5'h08, p + 32'h6);
    note(XAU_EX_FPU, vb + XAU_VOFF_FPU, p + 32'h6, 1, 1);
    dec(XAU_CLS_PLAIN, p, 8'h00);
    dec(XAU_CLS_PLAIN, p, 8'h00);
    flash_loader_download_i <= 1'b0;
    note(XAU_EX_IRQ, vb + {22'h0, tv, 2'b00}, p, 1, 1);
    dec(XAU_CLS_PLAIN, p, 8'h00);
    dec(XAU_CLS_DBRANCH, p, 8'h00);
    note(XAU_EX_SLOTIL, vb + XAU_VOFF_SLOTIL, p + 32'h40, 1, 1);
    dec(XAU_CLS_UNDEF, p, 8'h00);
    note(XAU_EX_GENILL, vb + XAU_VOFF_GENILL, p, 1, 1);
    dec(XAU_CLS_UNDEF, p, 8'h00);
    sp = 32'h0000_3002;
    apb(1, XAU_ADDR_SPTR, sp, 0);
    tv = 8'(rnd());
    note(XAU_EX_TRAP, vb + {22'h0, tv, 2'b00}, 0, 0, 0);
    note(XAU_EX_ADRERR, vb + XAU_VOFF_ADRERR, 0, 0, 0);
    dec(XAU_CLS_TRAP, p, tv);
    apb(0, XAU_ADDR_SPTR, 0, {1'b0, sp});
    repeat (4) @(posedge clk_i);
    chk(rq.size() + eq.size(), 0);
    complete_run();
  end
endmodule
`default_nettype wire

// *** xau_pkg.sv ***
// Behaviour
// - fp exception only when invalid or divide-by-zero enable is set and it occurs
// - only add, sub, mul, div, mac, compares, negate, abs, truncate can trap
// - on an enabled condition the fpu suspends and reports to the core
// - fp entry pushes status and next address, then vectors to base plus 0x34
// - fp flag bits accumulate for all but data transfer fp instructions and stay set until software clears them
// - fp cause bits are rewritten by every executed fp instruction
// - underflow, overflow and inexact are recorded but never trap
// - data transfer fp instructions, integer-to-float included, never trap
// - a refused source stays pending until an accepting instruction is decoded
// - right after a delayed branch nothing is accepted
// - after a system register load or store only fp exceptions are accepted
// - after an fp instruction only fp exceptions are accepted
// - each frame: return address at final pointer, status word one word above
// - return address depends on exception kind
// - a misaligned stack pointer during stacking raises an address error
// - stacking address error runs after the entry; nested ones are ignored
// - stacking writes still happen at the misaligned pointer, minus four each
// - interrupts wait while the flash loader download is running
// - status word is pushed first, program counter second
package xau_pkg;

  // apb register byte offsets
  localparam logic [7:0]  XAU_ADDR_FPSCW  = 8'h00;
  localparam logic [7:0]  XAU_ADDR_VBASE  = 8'h04;
  localparam logic [7:0]  XAU_ADDR_SPTR   = 8'h08;
  localparam logic [7:0]  XAU_ADDR_STATUS = 8'h0C;

  // fp status/control word layout, five-bit groups
  localparam int          XAU_FLAG_LSB    = 2;
  localparam int          XAU_EN_LSB      = 7;
  localparam int          XAU_CAUSE_LSB   = 12;
  localparam int          XAU_FX_INEXACT  = 0;
  localparam int          XAU_FX_UNDER    = 1;
  localparam int          XAU_FX_OVER     = 2;
  localparam int          XAU_FX_DIVZ     = 3;
  localparam int          XAU_FX_INVAL    = 4;
  localparam logic [4:0]  XAU_TRAP_MASK   = 5'h18;

  // reset values
  localparam logic [31:0] XAU_FPSCW_RST   = 32'h0000_0000;
  localparam logic [31:0] XAU_VBASE_RST   = 32'h0000_0000;
  localparam logic [31:0] XAU_SPTR_RST    = 32'h0000_0000;

  // vector table offsets and stack step
  localparam logic [31:0] XAU_VOFF_FPU    = 32'h0000_0034;
  localparam logic [31:0] XAU_VOFF_ADRERR = 32'h0000_0024;
  localparam logic [31:0] XAU_VOFF_BUSERR = 32'h0000_0020;
  localparam logic [31:0] XAU_VOFF_GENILL = 32'h0000_0010;
  localparam logic [31:0] XAU_VOFF_SLOTIL = 32'h0000_0018;
  localparam logic [31:0] XAU_SP_STEP     = 32'h0000_0004;

  typedef enum logic [2:0] {
    XAU_CLS_PLAIN, XAU_CLS_DBRANCH, XAU_CLS_PCWRITE, XAU_CLS_SYSREG,
    XAU_CLS_FP, XAU_CLS_TRAP, XAU_CLS_UNDEF
  } xau_cls_t;

  typedef enum logic [3:0] {
    XAU_FP_ADD, XAU_FP_SUB, XAU_FP_MUL, XAU_FP_DIV, XAU_FP_MAC, XAU_FP_CMPEQ,
    XAU_FP_CMPGT, XAU_FP_NEG, XAU_FP_ABS, XAU_FP_TRC, XAU_FP_FLOAT, XAU_FP_MOVE
  } xau_fpop_t;

  typedef enum logic [2:0] {
    XAU_EX_ADRERR, XAU_EX_BUSERR, XAU_EX_IRQ, XAU_EX_FPU,
    XAU_EX_TRAP, XAU_EX_GENILL, XAU_EX_SLOTIL
  } xau_exc_t;

  typedef enum logic [1:0] {
    XAU_ST_IDLE, XAU_ST_PUSH_SR, XAU_ST_PUSH_PC, XAU_ST_VECTOR
  } xau_state_t;

  typedef struct packed {
    logic        valid;
    xau_cls_t    cls;
    logic [31:0] pc;
    logic [31:0] next_pc;
    logic [31:0] target;
    logic [7:0]  trap_vec;
  } xau_dec_t;

  typedef struct packed {
    logic        done;
    xau_fpop_t   op;
    logic [4:0]  cond;
    logic [31:0] next_pc;
  } xau_fpu_rpt_t;

  typedef struct packed {
    logic        we;
    logic        misalign;
    logic [31:0] addr;
    logic [31:0] data;
  } xau_stk_t;

  typedef struct packed {
    logic        valid;
    xau_exc_t    kind;
    logic [31:0] addr;
  } xau_vec_t;

endpackage

// *** xau_stack_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module xau_stack_model
  import xau_pkg::*;
#(
  parameter logic [31:0] STATUS_WORD = 32'h0000_00F0
)(
  input  wire logic     clk_i,
  input  wire logic     nrst_i,
  input  wire xau_stk_t stk_i,
  output logic [31:0]   proc_status_word_o,
  output logic [31:0]   sr_addr_o,
  output logic [31:0]   sr_o,
  output logic [31:0]   ret_o
);
  logic we_d_r;
  assign proc_status_word_o = STATUS_WORD;
  // memory takes every write, misaligned too; first of a pair is the status word
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      we_d_r <= 1'b0;
      sr_addr_o <= 32'h0000_0000;
      sr_o <= 32'h0000_0000;
      ret_o <= 32'h0000_0000;
    end else begin
      we_d_r <= stk_i.we;
      if (stk_i.we && !we_d_r) begin
        sr_addr_o <= stk_i.addr;
        sr_o <= stk_i.data;
      end else if (stk_i.we) begin
        ret_o <= stk_i.data;
      end
    end
  end
endmodule
`default_nettype wire
